//--- sim/psbp_checker_assertions.sv
// concurrent checks on the ports of the pll status block
`timescale 1ns/1ps
`include "psbp_regs.vh"

module psbp_checker #(
  parameter ERR_W   = 8,
  parameter REF_DIV = 8,
  parameter N_ACQ   = 8,
  parameter N_TRK   = 16
) (
  input wire                    i_mclk,
  input wire                    i_rst,
  input wire [`PSBP_ADDR_W-1:0] i_addr,
  input wire [7:0]              i_wdata,
  input wire                    i_wr,
  input wire                    i_rd,
  input wire                    i_break_state,
  input wire [ERR_W-1:0]        i_freq_error,
  input wire [7:0]              o_rdata,
  input wire                    o_pll_irq,
  input wire                    o_tracking,
  input wire                    o_lock,
  input wire                    o_break_flag_clear_enable
);
  // ----------------------------------------------------------------
  // shadow of the writable controls
  // ----------------------------------------------------------------
  // margins cover the 4 clock error sync and the registered outputs
  localparam int TRK_WAIT  = 4*REF_DIV*N_ACQ+12;
  localparam int LOCK_WAIT = 4*REF_DIV*(N_ACQ+N_TRK)+12;
  reg        auto_on, irq_en, cib;
  reg [7:0]  trk_tol, lock_tol, quiet;
  reg [15:0] trk_cnt, lock_cnt;
  wire rd_ctl = i_rd && i_addr == `PSBP_OFF_PLL_CTL;
  wire prot   = i_break_state && !o_break_flag_clear_enable;
  wire wr_cfg = i_wr && i_addr != `PSBP_OFF_PLL_CTL && i_addr != `PSBP_OFF_BRK_CTL;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      auto_on  <= 1'b0;
      irq_en   <= 1'b0;
      cib      <= 1'b0;
      quiet    <= 8'h00;
      trk_tol  <= `PSBP_TRK_TOL_RST;
      lock_tol <= `PSBP_LOCK_TOL_RST;
      trk_cnt  <= 16'h0000;
      lock_cnt <= 16'h0000;
    end else begin
      if (i_wr && i_addr == `PSBP_OFF_PLL_CTL) irq_en <= i_wdata[7];
      if (i_wr && i_addr == `PSBP_OFF_PLL_BWC) auto_on <= i_wdata[7];
      if (i_wr && i_addr == `PSBP_OFF_TRK_TOL) trk_tol <= i_wdata;
      if (i_wr && i_addr == `PSBP_OFF_LOCK_TOL) lock_tol <= i_wdata;
      quiet <= $changed(o_lock) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
      if ($changed(o_lock)) cib <= 1'b0;
      else if (rd_ctl) cib <= i_break_state && o_break_flag_clear_enable && quiet > 8'h04;
      trk_cnt  <= (!auto_on || wr_cfg || i_freq_error >= trk_tol) ? 16'h0000 : trk_cnt + 16'h0001;
      lock_cnt <= (!auto_on || wr_cfg || i_freq_error >= lock_tol) ? 16'h0000 : lock_cnt + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  brk_clear_a: assert property (
    rd_ctl && i_break_state && o_break_flag_clear_enable && cib && quiet > 8'h08 |=> !o_rdata[6])
    else $error("flag survived a permitted break read");
  stays_clear_a: assert property (
    rd_ctl && !i_break_state && cib && quiet > 8'h08 |=> !o_rdata[6])
    else $error("flag restored after break");
  brk_protect_a: assert property (
    rd_ctl && prot ##1 o_rdata[6] && !i_wr ##1 rd_ctl && prot |=> o_rdata[6])
    else $error("protected flag was cleared");
  bce_reset_a: assert property ($fell(i_rst) |-> !o_break_flag_clear_enable)
    else $error("clear enable set after reset");
  trk_set_a: assert property (trk_cnt > TRK_WAIT |-> o_tracking)
    else $error("tracking indicator late");
  lock_set_a: assert property (lock_cnt > LOCK_WAIT |-> o_lock)
    else $error("lock indicator late");
  lock_irq_a: assert property (auto_on && irq_en && $changed(o_lock) |-> ##[1:4] o_pll_irq)
    else $error("no request on lock change");
  manual_off_a: assert property (!auto_on [*3] |-> !o_lock && !o_pll_irq)
    else $error("lock or request in manual mode");
  manual_flag_a: assert property (rd_ctl && !auto_on |=> !o_rdata[6])
    else $error("flag read as one in manual mode");
  cover property (rd_ctl && prot);
  cover property ($rose(o_lock));
  cover property (rd_ctl && cib);
endmodule

//--- sim/psbp_siu_model.sv
// model of the break source and of the pll error seen by the status block
`timescale 1ns/1ps

module psbp_siu_model (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_break_req,
  input  wire [7:0] i_err_target,
  output reg        o_break_state,
  output reg  [7:0] o_freq_error
);
  // error settles in steps of 16 but jumps up at once, like a noise hit
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_break_state <= 1'b0;
      o_freq_error  <= 8'hFF;
    end else begin
      o_break_state <= i_break_req;
      // nine bits so a target near the top cannot wrap and start a ramp
      if ({1'b0, o_freq_error} > {1'b0, i_err_target} + 9'h010)
        o_freq_error <= o_freq_error - 8'h10;
      else
        o_freq_error <= i_err_target;
    end
  end
endmodule

//--- sim/test_psbp_top.sv
// self-checking bench for the pll status block
`timescale 1ns/1ps
`include "psbp_regs.vh"

`define CHK(nm, ex, got) begin \
  num_checks = num_checks + 1; \
  if ((got) !== (ex)) begin \
    mismatches = mismatches + 1; \
    $display("[ERR] %0s exp %h got %h", nm, ex, got); \
  end end

module test_psbp_top;
  reg        i_mclk = 1'b0;
  reg        i_rst = 1'b1;
  reg  [3:0] i_addr = 4'h0;
  reg  [7:0] i_wdata = 8'h00;
  reg        i_wr = 1'b0;
  reg        i_rd = 1'b0;
  reg        brk_req = 1'b0;
  reg  [7:0] err_tgt = 8'hFF;
  wire       brk, o_pll_irq, o_tracking, o_lock, o_break_flag_clear_enable;
  wire [7:0] ferr, o_rdata;
  wire [2:0] ind = {o_pll_irq, o_lock, o_tracking};
  integer    mismatches = 0;
  integer    num_checks = 0;
  integer    n;

  always #10 i_mclk = ~i_mclk;

  psbp_siu_model u_siu (.i_mclk(i_mclk), .i_rst(i_rst), .i_break_req(brk_req), .i_err_target(err_tgt),
    .o_break_state(brk), .o_freq_error(ferr));
  psbp_top #(.REF_DIV(2), .N_ACQ(2), .N_TRK(2)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_break_state(brk), .i_freq_error(ferr),
    .o_rdata(o_rdata), .o_pll_irq(o_pll_irq), .o_tracking(o_tracking), .o_lock(o_lock),
    .o_break_flag_clear_enable(o_break_flag_clear_enable));

  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  task test_done;
    begin
      if (mismatches == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, input [7:0] ex, input [8*12:1] nm);
    begin
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      `CHK(nm, ex, o_rdata)
    end
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task wait_for(input integer sel, input ex, input [8*12:1] nm);
    begin
      n = 0;
      while (n < 300 && ind[sel] !== ex) begin
        @(posedge i_mclk);
        #1;
        n = n + 1;
      end
      `CHK(nm, ex, ind[sel])
      if (ind[sel] !== ex)
        test_done;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset_vals;
    begin
      `CHK("bce_out", 1'b0, o_break_flag_clear_enable)
      rd(`PSBP_OFF_BRK_CTL, 8'h00, "brk_ctl");
      rd(`PSBP_OFF_PLL_CTL, `PSBP_CTL_UNIMP, "ctl_rst");
      rd(`PSBP_OFF_TRK_TOL, `PSBP_TRK_TOL_RST, "trk_tol");
      rd(`PSBP_OFF_LOCK_TOL, `PSBP_LOCK_TOL_RST, "lock_tol");
      rd(4'h7, 8'h00, "unmapped");
    end
  endtask

  task t_manual;
    begin
      err_tgt <= 8'h00;
      wr(`PSBP_OFF_PLL_CTL, 8'h80);
      wr(`PSBP_OFF_PLL_BWC, 8'h20);
      repeat (60) @(posedge i_mclk);
      #1;
      `CHK("man_lock", 1'b0, o_lock)
      `CHK("man_irq", 1'b0, o_pll_irq)
      rd(`PSBP_OFF_PLL_BWC, 8'h20, "man_bwc");
      rd(`PSBP_OFF_PLL_CTL, 8'h8F, "man_ctl");
    end
  endtask

  task t_lock;
    begin
      // drop to manual first so each call starts a fresh acquisition and sees a lock edge
      wr(`PSBP_OFF_PLL_BWC, 8'h00);
      repeat (4) @(posedge i_mclk);
      wr(`PSBP_OFF_PLL_BWC, 8'h80);
      wait_for(0, 1'b1, "trk_on");
      wait_for(1, 1'b1, "lock_on");
      wait_for(2, 1'b1, "irq_on");
      rd(`PSBP_OFF_PLL_BWC, 8'hE0, "auto_bwc");
    end
  endtask

  task t_protect;
    begin
      brk_req <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "prot_rd1");
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "prot_rd2");
      wr(`PSBP_OFF_PLL_CTL, 8'h80);
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "prot_wr");
      brk_req <= 1'b0;
      repeat (3) @(posedge i_mclk);
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "run_rd1");
      rd(`PSBP_OFF_PLL_CTL, 8'h8F, "run_rd2");
      wait_for(2, 1'b0, "irq_off");
    end
  endtask

  task t_unlock;
    begin
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "unl_clr");
      wait_for(2, 1'b0, "unl_irq0");
      err_tgt <= 8'hFF;
      wait_for(0, 1'b0, "trk_off");
      wait_for(1, 1'b0, "lock_off");
      wait_for(2, 1'b1, "irq_drop");
    end
  endtask

  task t_break_clear;
    begin
      wr(`PSBP_OFF_BRK_CTL, 8'h80);
      brk_req <= 1'b1;
      repeat (8) @(posedge i_mclk);
      #1;
      `CHK("bce_set", 1'b1, o_break_flag_clear_enable)
      rd(`PSBP_OFF_PLL_CTL, 8'hCF, "brk_rd1");
      rd(`PSBP_OFF_PLL_CTL, 8'h8F, "brk_rd2");
      brk_req <= 1'b0;
      repeat (3) @(posedge i_mclk);
      rd(`PSBP_OFF_PLL_CTL, 8'h8F, "after_brk");
      `CHK("after_irq", 1'b0, o_pll_irq)
    end
  endtask

  task t_auto_off;
    begin
      err_tgt <= 8'h00;
      wait_for(1, 1'b1, "relock");
      wr(`PSBP_OFF_PLL_BWC, 8'h00);
      repeat (4) @(posedge i_mclk);
      #1;
      `CHK("off_irq", 1'b0, o_pll_irq)
      `CHK("off_lock", 1'b0, o_lock)
      rd(`PSBP_OFF_PLL_CTL, 8'h8F, "off_ctl");
    end
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset_vals;
    t_manual;
    t_lock;
    t_protect;
    t_lock;
    t_unlock;
    t_break_clear;
    t_auto_off;
    test_done;
  end
endmodule

bind psbp_top psbp_checker #(.ERR_W(ERR_W), .REF_DIV(REF_DIV), .N_ACQ(N_ACQ), .N_TRK(N_TRK)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_break_state(i_break_state), .i_freq_error(i_freq_error), .o_rdata(o_rdata), .o_pll_irq(o_pll_irq),
  .o_tracking(o_tracking), .o_lock(o_lock), .o_break_flag_clear_enable(o_break_flag_clear_enable));

//--- src/psbp_regs.vh
// register offsets, field positions, reset values and timing counts of the pll status block
`ifndef PSBP_REGS_VH
`define PSBP_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, 8-bit data)
// ----------------------------------------------------------------
`define PSBP_ADDR_W          4
`define PSBP_OFF_PLL_CTL     4'h0
`define PSBP_OFF_PLL_BWC     4'h1
`define PSBP_OFF_BRK_CTL     4'h2
`define PSBP_OFF_TRK_TOL     4'h3
`define PSBP_OFF_LOCK_TOL    4'h4

// ----------------------------------------------------------------
// pll_control_reg fields
// ----------------------------------------------------------------
`define PSBP_CTL_IE_BIT      7
`define PSBP_CTL_FLAG_BIT    6
`define PSBP_CTL_UNIMP       8'h0F

// ----------------------------------------------------------------
// pll_bandwidth_control_reg fields
// ----------------------------------------------------------------
`define PSBP_BWC_AUTO_BIT    7
`define PSBP_BWC_LOCK_BIT    6
`define PSBP_BWC_TRK_BIT     5

// ----------------------------------------------------------------
// sim_break_flag_control fields
// ----------------------------------------------------------------
`define PSBP_BRK_BCE_BIT     7

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define PSBP_TRK_TOL_RST     8'h20
`define PSBP_LOCK_TOL_RST    8'h08
`define PSBP_REF_DIV         8
`define PSBP_N_ACQ           8
`define PSBP_N_TRK           16

`endif

//--- src/psbp_tol_qual.v
// tolerance qualifier: flags an error that stays below a limit for n reference samples
`timescale 1ns/1ps

module psbp_tol_qual #(
  parameter W     = 8,
  parameter N_CNT = 8
) (
  input  wire         i_mclk,
  input  wire         i_rst,
  input  wire         i_run,
  input  wire         i_sample,
  input  wire [W-1:0] i_err,
  input  wire [W-1:0] i_tol,
  output reg          o_ok
);

  // ----------------------------------------------------------------
  // consecutive in-tolerance sample counter
  // ----------------------------------------------------------------
  reg [15:0] cnt;

  // one sample out of tolerance restarts the whole measurement, so a
  // noisy error never qualifies on an average alone
  always @(posedge i_mclk) begin
    if (i_rst || !i_run) begin
      cnt  <= 16'h0000;
      o_ok <= 1'b0;
    end else if (i_sample) begin
      if (i_err < i_tol) begin
        if (cnt >= N_CNT[15:0] - 16'h0001) begin
          o_ok <= 1'b1;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end else begin
        cnt  <= 16'h0000;
        o_ok <= 1'b0;
      end
    end
  end

endmodule

//--- src/psbp_top.v
// pll status flags with lock-change flag protection during debug break
//
// Summary of operation
// - with break active and the break clear enable set, reading the control register clears the flag as normal.
// - a flag cleared during break stays cleared after break ends; nothing restores it.
// - with break active and the break clear enable zero, control register accesses leave the flag alone.
// - the break clear enable is zero after reset, protecting the flag by default.
// - in automatic mode the tracking indicator sets once the error stays under the tracking tolerance.
// - in automatic mode the lock indicator sets once tracking has qualified and the error then stays under the lock tolerance.
// - in automatic mode every lock change sets the flag and requests an interrupt when enabled.
// - in manual mode interrupts are off and the flag reads as zero.
`timescale 1ns/1ps
`include "psbp_regs.vh"

module psbp_top #(
  parameter ERR_W   = 8,
  parameter REF_DIV = `PSBP_REF_DIV,
  parameter N_ACQ   = `PSBP_N_ACQ,
  parameter N_TRK   = `PSBP_N_TRK
) (
  input  wire                   i_mclk,
  input  wire                   i_rst,
  input  wire [`PSBP_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  input  wire                   i_break_state,
  input  wire [ERR_W-1:0]       i_freq_error,
  output reg  [7:0]             o_rdata,
  output reg                    o_pll_irq,
  output reg                    o_tracking,
  output reg                    o_lock,
  output reg                    o_break_flag_clear_enable
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg             pll_interrupt_enable;
  reg             pll_lock_change_flag;
  reg             auto_mode;
  reg             manual_trk;
  reg             break_flag_clear_enable;
  reg [ERR_W-1:0] trk_tol;
  reg [ERR_W-1:0] lock_tol;
  reg             tracking_mode_indicator;
  reg             lock_ind;
  reg             lock_prev;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function sel;
    input [`PSBP_ADDR_W-1:0] a;
    input [`PSBP_ADDR_W-1:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  wire wr_ctl  = i_wr && sel(i_addr, `PSBP_OFF_PLL_CTL);
  wire wr_bwc  = i_wr && sel(i_addr, `PSBP_OFF_PLL_BWC);
  wire wr_brk  = i_wr && sel(i_addr, `PSBP_OFF_BRK_CTL);
  wire wr_ttol = i_wr && sel(i_addr, `PSBP_OFF_TRK_TOL);
  wire wr_ltol = i_wr && sel(i_addr, `PSBP_OFF_LOCK_TOL);
  wire rd_ctl  = i_rd && sel(i_addr, `PSBP_OFF_PLL_CTL);

  // ----------------------------------------------------------------
  // frequency error synchroniser
  // ----------------------------------------------------------------
  // the error word comes from the analog side; it is taken only when
  // stages two and three agree, so a word caught mid-change is skipped
  reg [ERR_W-1:0] err_s1;
  reg [ERR_W-1:0] err_s2;
  reg [ERR_W-1:0] err_s3;
  reg [ERR_W-1:0] err_q;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      err_s1 <= {ERR_W{1'b1}};
      err_s2 <= {ERR_W{1'b1}};
      err_s3 <= {ERR_W{1'b1}};
      err_q  <= {ERR_W{1'b1}};
    end else begin
      err_s1 <= i_freq_error;
      err_s2 <= err_s1;
      err_s3 <= err_s2;
      if (err_s2 == err_s3) begin
        err_q <= err_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference sample divider
  // ----------------------------------------------------------------
  reg [15:0] div_cnt;
  reg        ref_tick;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      div_cnt  <= 16'h0000;
      ref_tick <= 1'b0;
    end else if (div_cnt >= REF_DIV[15:0] - 16'h0001) begin
      div_cnt  <= 16'h0000;
      ref_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 16'h0001;
      ref_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // acquisition and lock qualification
  // ----------------------------------------------------------------
  wire trk_ok;
  wire lock_ok;

  psbp_tol_qual #(
    .W     (ERR_W),
    .N_CNT (N_ACQ)
  ) u_trk_qual (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_run    (auto_mode),
    .i_sample (ref_tick),
    .i_err    (err_q),
    .i_tol    (trk_tol),
    .o_ok     (trk_ok)
  );

  // lock is measured only after acquisition has ended
  psbp_tol_qual #(
    .W     (ERR_W),
    .N_CNT (N_TRK)
  ) u_lock_qual (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_run    (auto_mode && trk_ok),
    .i_sample (ref_tick),
    .i_err    (err_q),
    .i_tol    (lock_tol),
    .o_ok     (lock_ok)
  );

  always @(posedge i_mclk) begin
    if (i_rst) begin
      tracking_mode_indicator <= 1'b0;
      lock_ind                <= 1'b0;
      lock_prev               <= 1'b0;
    end else begin
      tracking_mode_indicator <= auto_mode && trk_ok;
      lock_ind                <= auto_mode && lock_ok;
      lock_prev               <= lock_ind;
    end
  end

  wire lock_edge = auto_mode && (lock_ind != lock_prev);

  // ----------------------------------------------------------------
  // lock change flag
  // ----------------------------------------------------------------
  // a read of the control register clears the flag; in break the read
  // is harmless unless the break clear enable is set, so a debugger can
  // inspect the register without losing a pending lock event
  wire clr_allowed = !i_break_state || break_flag_clear_enable;
  wire flag_clear  = rd_ctl && clr_allowed;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      pll_lock_change_flag <= 1'b0;
    end else if (!auto_mode) begin
      pll_lock_change_flag <= 1'b0;
    end else if (lock_edge) begin
      pll_lock_change_flag <= 1'b1;
    end else if (flag_clear) begin
      pll_lock_change_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software writable registers
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (i_rst) begin
      pll_interrupt_enable    <= 1'b0;
      auto_mode               <= 1'b0;
      manual_trk              <= 1'b0;
      break_flag_clear_enable <= 1'b0;
      trk_tol                 <= `PSBP_TRK_TOL_RST;
      lock_tol                <= `PSBP_LOCK_TOL_RST;
    end else begin
      if (wr_ctl) begin
        pll_interrupt_enable <= i_wdata[`PSBP_CTL_IE_BIT];
      end
      if (wr_bwc) begin
        auto_mode <= i_wdata[`PSBP_BWC_AUTO_BIT];
        // the manual tracking value is held while automatic mode runs
        // and comes back when software returns to manual mode
        if (!auto_mode) begin
          manual_trk <= i_wdata[`PSBP_BWC_TRK_BIT];
        end
      end
      if (wr_brk) begin
        break_flag_clear_enable <= i_wdata[`PSBP_BRK_BCE_BIT];
      end
      if (wr_ttol) begin
        trk_tol <= i_wdata[ERR_W-1:0];
      end
      if (wr_ltol) begin
        lock_tol <= i_wdata[ERR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (i_addr)
      `PSBP_OFF_PLL_CTL: begin
        next_rdata = `PSBP_CTL_UNIMP;
        next_rdata[`PSBP_CTL_IE_BIT]   = pll_interrupt_enable;
        next_rdata[`PSBP_CTL_FLAG_BIT] = pll_lock_change_flag && auto_mode;
      end
      `PSBP_OFF_PLL_BWC: begin
        next_rdata[`PSBP_BWC_AUTO_BIT] = auto_mode;
        next_rdata[`PSBP_BWC_LOCK_BIT] = lock_ind && auto_mode;
        next_rdata[`PSBP_BWC_TRK_BIT]  = auto_mode ? tracking_mode_indicator : manual_trk;
      end
      `PSBP_OFF_BRK_CTL: begin
        next_rdata[`PSBP_BRK_BCE_BIT] = break_flag_clear_enable;
      end
      `PSBP_OFF_TRK_TOL: begin
        next_rdata[ERR_W-1:0] = trk_tol;
      end
      `PSBP_OFF_LOCK_TOL: begin
        next_rdata[ERR_W-1:0] = lock_tol;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata                   <= 8'h00;
      o_pll_irq                 <= 1'b0;
      o_tracking                <= 1'b0;
      o_lock                    <= 1'b0;
      o_break_flag_clear_enable <= 1'b0;
    end else begin
      o_rdata                   <= i_rd ? next_rdata : 8'h00;
      o_pll_irq                 <= auto_mode && pll_interrupt_enable && pll_lock_change_flag;
      o_tracking                <= auto_mode ? tracking_mode_indicator : manual_trk;
      o_lock                    <= lock_ind;
      o_break_flag_clear_enable <= break_flag_clear_enable;
    end
  end

endmodule
